// *** hdl/pfg_defs.svh ***
`ifndef PFG_DEFS_SVH
`define PFG_DEFS_SVH

// register byte addresses on the 8-bit port
`define PFG_A_CNT_LO    8'h00
`define PFG_A_CMPA_LO   8'h01
`define PFG_A_CMPB_LO   8'h02
`define PFG_A_CMPC_LO   8'h03
`define PFG_A_CMPD_LO   8'h04
`define PFG_A_HI_LATCH  8'h05
`define PFG_A_CTRL_A    8'h06
`define PFG_A_CTRL_B    8'h07
`define PFG_A_CTRL_D    8'h08
`define PFG_A_IRQ_STAT  8'h09
`define PFG_A_IRQ_MASK  8'h0A

// control register A: compare output modes, two bits per channel
`define PFG_CA_RESET    8'h00
// control register B: channel D compare output mode in bits 1:0
`define PFG_CB_RESET    8'h00

// control register D fields
`define PFG_CD_GUARD_EN 0
`define PFG_CD_SRC_CMP  1
`define PFG_CD_FILT_EN  2
`define PFG_CD_IRQ_EN   3
`define PFG_CD_FLAG     4
`define PFG_CD_RESET    8'h00

// interrupt status and mask fields
`define PFG_IS_FAULT    0

// filter depth and delay
`define PFG_FILT_DEPTH  4
`define PFG_FILT_DELAY_NS 20
`define PFG_CLK_PERIOD_NS 5
`define PFG_FILT_DELAY_CYC ((`PFG_FILT_DELAY_NS + `PFG_CLK_PERIOD_NS - 1) / `PFG_CLK_PERIOD_NS)

`endif

// *** hdl/pfg_pkg.sv ***
package pfg_pkg;
	typedef logic [7:0] pfg_byte_t;
	typedef logic [9:0] pfg_wide_t;
	typedef logic [1:0] pfg_com_t;
	typedef enum logic [1:0] {
		PFG_ARMED,
		PFG_TRIPPED,
		PFG_IDLE
	} pfg_state_t;
endpackage

// *** hdl/pfg_filter.sv ***
`include "pfg_defs.svh"

// four-sample agreement filter with edge detector
module pfg_filter #(
	parameter int DEPTH = `PFG_FILT_DEPTH
) (
	input  wire logic i_clk,     // system clock
	input  wire logic i_rst_n,   // synchronous-released reset
	input  wire logic i_din,     // selected trigger level
	input  wire logic i_filt_en, // filter insert
	output logic      o_edge     // one-cycle change pulse
);
	logic [DEPTH-1:0] pipe_q;
	logic             filt_q;
	logic             prev_q;
	logic             level;

	// sample pipeline on the system clock, no prescaler
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pipe_q <= '0;
		end else begin
			pipe_q <= {pipe_q[DEPTH-2:0], i_din};
		end
	end

	// filtered level moves only when all samples agree
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			filt_q <= 1'b0;
		end else if (&pipe_q) begin
			filt_q <= 1'b1;
		end else if (~|pipe_q) begin
			filt_q <= 1'b0;
		end
	end

	// filter in or bypassed ahead of the edge detector
	assign level = i_filt_en ? filt_q : pipe_q[0];

	// edge detector: any level change
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= level;
		end
	end

	assign o_edge = level ^ prev_q;
endmodule

// *** hdl/pfg_wide_regs.sv ***
`include "pfg_defs.svh"

// 10-bit counter and compare registers behind one shared high latch
module pfg_wide_regs
	import pfg_pkg::*;
#(
	parameter int NCMP = 4
) (
	input  wire logic              i_clk,     // system clock
	input  wire logic              i_rst_n,   // reset
	input  wire logic              i_tick,    // timer tick enable
	input  wire logic [7:0]        i_addr,    // register address
	input  wire logic [7:0]        i_wdata,   // write data
	input  wire logic              i_wr,      // write strobe
	input  wire logic              i_rd,      // read strobe
	output pfg_pkg::pfg_byte_t     o_rdata,   // low byte or latch read value
	output logic                   o_hit,     // address belongs here
	output pfg_pkg::pfg_wide_t     o_count,   // counter value
	output logic [NCMP*10-1:0]     o_cmp      // compare values
);
	pfg_wide_t  cnt_q;
	pfg_wide_t  cmp_q [NCMP];
	logic [1:0] hi_q;
	logic       cnt_sel;
	logic [NCMP-1:0] cmp_sel;
	logic       hi_sel;
	pfg_wide_t  rd_word;

	assign cnt_sel = (i_addr == `PFG_A_CNT_LO);
	assign hi_sel  = (i_addr == `PFG_A_HI_LATCH);
	assign o_hit   = cnt_sel | hi_sel | (|cmp_sel);

	// counter: low-byte write loads latch plus byte, else count on tick
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
		end else if (i_wr && cnt_sel) begin
			cnt_q <= {hi_q, i_wdata};
		end else if (i_tick) begin
			cnt_q <= cnt_q + 10'h001;
		end
	end

	// compare registers, one per channel
	genvar g;
	generate
		for (g = 0; g < NCMP; g++) begin : g_cmp
			assign cmp_sel[g] = (i_addr == (`PFG_A_CMPA_LO + 8'(g)));
			assign o_cmp[g*10 +: 10] = cmp_q[g];
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					cmp_q[g] <= '0;
				end else if (i_wr && cmp_sel[g]) begin
					cmp_q[g] <= {hi_q, i_wdata};
				end
			end
		end
	endgenerate

	// word addressed by a low-byte read
	always_comb begin
		rd_word = cnt_q;
		for (int k = 0; k < NCMP; k++) begin
			if (cmp_sel[k]) begin
				rd_word = cmp_q[k];
			end
		end
	end

	// shared high latch: cpu write, or capture on low-byte read
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hi_q <= 2'h0;
		end else if (i_wr && hi_sel) begin
			hi_q <= i_wdata[1:0];
		end else if (i_rd && (cnt_sel | (|cmp_sel))) begin
			hi_q <= rd_word[9:8];
		end
		// low-byte writes leave the latch alone
	end

	// read data registered one cycle later
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd && hi_sel) begin
			o_rdata <= {6'h00, hi_q};
		end else if (i_rd) begin
			o_rdata <= rd_word[7:0];
		end
	end

	assign o_count = cnt_q;
endmodule

// *** hdl/pfg_top.sv ***
// Summary of operation
// - guard enabled: trigger level change starts fault
// - comparator select bit picks comparator source
// - fault clears modes, pins revert to port
// - guard enable self-clears with mode clear
// - irq enable set: fault raises interrupt
// - source change may itself cause fault
// - four-sample pipeline, output changes on agreement
// - filter enable adds four-cycle filter
// - filter runs on raw system clock
// - port-driven trigger pin acts as external
// - one shared 2-bit high latch
// - low-byte write loads latch plus byte
// - low-byte read captures high bits
// - latch kept across low-byte writes
//
// Design decisions made here: the register offsets and strobed register access.
`include "pfg_defs.svh"

module pfg_top
	import pfg_pkg::*;
#(
	parameter int NCMP = 4,
	parameter int NPIN = 6
) (
	input  wire logic            I_CLK,        // 200 MHz system clock
	input  wire logic            I_ARST_N,     // async reset, active low
	input  wire logic            I_TICK,       // timer tick enable
	input  wire logic [7:0]      I_ADDR,       // register address
	input  wire logic [7:0]      I_WDATA,      // write data
	input  wire logic            I_WR,         // write strobe
	input  wire logic            I_RD,         // read strobe
	output pfg_pkg::pfg_byte_t   O_RDATA,      // read data, cycle after strobe
	input  wire logic            I_EXT_PIN,    // external trigger pin level
	input  wire logic            I_CMP_RESULT, // comparator result
	input  wire logic [NPIN-1:0] I_WAVE,       // compare waveforms
	input  wire logic [NPIN-1:0] I_PORT_OUT,   // port output latch bits
	output logic [NPIN-1:0]      O_PIN,        // pwm pin values
	output pfg_pkg::pfg_wide_t   O_COUNT,      // counter value
	output logic [NCMP*10-1:0]   O_CMP,        // compare values
	output logic                 O_IRQ         // level interrupt
);
	logic       rst_meta_q;
	logic       rst_n;
	pfg_byte_t  ctrl_a_q;
	pfg_byte_t  ctrl_b_q;
	logic       guard_en_q;
	logic       src_cmp_q;
	logic       filt_en_q;
	logic       irq_en_q;
	logic       flag_q;
	logic       stat_q;
	logic       mask_q;
	logic       trig_in;
	logic       trig_edge;
	logic       fault;
	logic       wide_hit;
	pfg_byte_t  wide_rdata;
	pfg_byte_t  rdata_q;
	logic       own_rd_q;
	pfg_state_t state_q;
	logic [NPIN-1:0] com_on;
	logic       wr_ctrl_a;
	logic       wr_ctrl_b;
	logic       wr_ctrl_d;
	logic       wr_stat;
	logic       wr_mask;
	logic       flag_clr;
	logic       stat_clr;
	logic       tripped;
	pfg_byte_t  ctrl_d_rd;
	pfg_byte_t  rd_mux;

	// reset release through two flops
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// trigger source mux; pin value may come from its own port drive
	assign trig_in = src_cmp_q ? I_CMP_RESULT : I_EXT_PIN;

	// filter and edge detector; a source switch may show as an edge
	pfg_filter #(
		.DEPTH (`PFG_FILT_DEPTH)
	) u_filter (
		.i_clk     (I_CLK),
		.i_rst_n   (rst_n),
		.i_din     (trig_in),
		.i_filt_en (filt_en_q),
		.o_edge    (trig_edge)
	);

	// fault fires from a detected edge while guard is enabled
	assign fault = trig_edge & guard_en_q;

	// register write decode
	assign wr_ctrl_a = I_WR && (I_ADDR == `PFG_A_CTRL_A);
	assign wr_ctrl_b = I_WR && (I_ADDR == `PFG_A_CTRL_B);
	assign wr_ctrl_d = I_WR && (I_ADDR == `PFG_A_CTRL_D);
	assign wr_stat   = I_WR && (I_ADDR == `PFG_A_IRQ_STAT);
	assign wr_mask   = I_WR && (I_ADDR == `PFG_A_IRQ_MASK);
	assign flag_clr  = wr_ctrl_d && I_WDATA[`PFG_CD_FLAG];
	assign stat_clr  = wr_stat && I_WDATA[`PFG_IS_FAULT];

	// event flag: set wins over software clear
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else if (trig_edge) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end

	// channel a/b compare output modes, cleared on fault
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a_q <= `PFG_CA_RESET;
		end else if (fault) begin
			ctrl_a_q <= 8'h00;
		end else if (wr_ctrl_a) begin
			ctrl_a_q <= I_WDATA;
		end
	end

	// channel d compare output mode, cleared on fault
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_b_q <= `PFG_CB_RESET;
		end else if (fault) begin
			ctrl_b_q <= 8'h00;
		end else if (wr_ctrl_b) begin
			ctrl_b_q <= I_WDATA;
		end
	end

	// control register D configuration bits
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			src_cmp_q <= 1'b0;
			filt_en_q <= 1'b0;
			irq_en_q  <= 1'b0;
		end else if (wr_ctrl_d) begin
			src_cmp_q <= I_WDATA[`PFG_CD_SRC_CMP];
			filt_en_q <= I_WDATA[`PFG_CD_FILT_EN];
			irq_en_q  <= I_WDATA[`PFG_CD_IRQ_EN];
		end
	end

	// guard enable drops in the same cycle as the modes
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			guard_en_q <= 1'b0;
		end else if (fault) begin
			guard_en_q <= 1'b0;
		end else if (wr_ctrl_d) begin
			guard_en_q <= I_WDATA[`PFG_CD_GUARD_EN];
		end
	end

	// guard sequencer for observation of armed/tripped
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= PFG_IDLE;
		end else begin
			case (state_q)
				PFG_IDLE: begin
					if (guard_en_q) begin
						state_q <= PFG_ARMED;
					end
				end
				PFG_ARMED: begin
					if (fault) begin
						state_q <= PFG_TRIPPED;
					end else if (!guard_en_q) begin
						state_q <= PFG_IDLE;
					end
				end
				PFG_TRIPPED: begin
					if (guard_en_q) begin
						state_q <= PFG_ARMED;
					end
				end
				default: begin
					state_q <= PFG_IDLE;
				end
			endcase
		end
	end

	// sequencer tripped state, visible in control register D
	assign tripped = (state_q == PFG_TRIPPED);

	// interrupt status: fault with irq enable sets, write one clears
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= 1'b0;
		end else if (fault && irq_en_q) begin
			stat_q <= 1'b1;
		end else if (stat_clr) begin
			stat_q <= 1'b0;
		end
	end

	// interrupt mask
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= 1'b0;
		end else if (wr_mask) begin
			mask_q <= I_WDATA[`PFG_IS_FAULT];
		end
	end

	// level interrupt while an unmasked status bit is set
	assign O_IRQ = stat_q & mask_q;

	// pin mux: channel pair active when its mode is nonzero
	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_pin
			if (g / 2 < 2) begin : g_ab
				assign com_on[g] = |ctrl_a_q[7 - 2*(g/2) -: 2];
			end else begin : g_d
				assign com_on[g] = |ctrl_b_q[1:0];
			end
			// port latch drives pins once modes are cleared
			assign O_PIN[g] = com_on[g] ? I_WAVE[g] : I_PORT_OUT[g];
		end
	endgenerate

	// wide registers with shared high latch
	pfg_wide_regs #(
		.NCMP (NCMP)
	) u_wide (
		.i_clk   (I_CLK),
		.i_rst_n (rst_n),
		.i_tick  (I_TICK),
		.i_addr  (I_ADDR),
		.i_wdata (I_WDATA),
		.i_wr    (I_WR),
		.i_rd    (I_RD),
		.o_rdata (wide_rdata),
		.o_hit   (wide_hit),
		.o_count (O_COUNT),
		.o_cmp   (O_CMP)
	);

	// marks a read served here rather than by the wide block
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			own_rd_q <= 1'b0;
		end else begin
			own_rd_q <= I_RD && !wide_hit;
		end
	end

	// control register D as read back, with the tripped state
	assign ctrl_d_rd = {2'h0, tripped, flag_q, irq_en_q, filt_en_q, src_cmp_q,
		guard_en_q};

	// local register select; unmapped addresses read zero
	always_comb begin
		rd_mux = 8'h00;
		case (I_ADDR)
			`PFG_A_CTRL_A: begin
				rd_mux = ctrl_a_q;
			end
			`PFG_A_CTRL_B: begin
				rd_mux = ctrl_b_q;
			end
			`PFG_A_CTRL_D: begin
				rd_mux = ctrl_d_rd;
			end
			`PFG_A_IRQ_STAT: begin
				rd_mux = {7'h00, stat_q};
			end
			`PFG_A_IRQ_MASK: begin
				rd_mux = {7'h00, mask_q};
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// local read data, registered one cycle after the strobe
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rd_mux;
		end
	end

	// wide block answers its own addresses
	assign O_RDATA = own_rd_q ? rdata_q : wide_rdata;
endmodule

// *** tb/pfg_checker.sv ***
module pfg_checker
	import pfg_pkg::*;
#(
	parameter int NCMP = 4,
	parameter int NPIN = 6
) (
	input wire logic                I_CLK,      // clock
	input wire logic                I_ARST_N,   // reset
	input wire logic [7:0]          I_ADDR,     // address
	input wire logic [7:0]          I_WDATA,    // write data
	input wire logic                I_WR,       // write
	input wire logic                I_RD,       // read
	input wire pfg_byte_t           O_RDATA,    // read data
	input wire logic [NPIN-1:0]     I_WAVE,     // waveforms
	input wire logic [NPIN-1:0]     I_PORT_OUT, // port bits
	input wire logic [NPIN-1:0]     O_PIN,      // pins
	input wire pfg_wide_t           O_COUNT,    // counter
	input wire logic [NCMP*10-1:0]  O_CMP,      // compares
	input wire logic                O_IRQ       // interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] up_q;

	// skip the internal reset copy
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) up_q <= 2'h0;
		else if (up_q != 2'h3) up_q <= up_q + 2'h1;
	end
	default clocking @(posedge I_CLK); endclocking
	default disable iff (up_q != 2'h3);

	property p_pin_sel;
		((O_PIN ^ I_WAVE) & (O_PIN ^ I_PORT_OUT)) == '0;
	endproperty
	a_pin_sel: assert property (p_pin_sel)
		else $error("pin is neither wave nor port");
	property p_cnt_wr;
		I_WR && I_ADDR == 8'h00 |=> O_COUNT[7:0] == $past(I_WDATA);
	endproperty
	a_cnt_wr: assert property (p_cnt_wr)
		else $error("counter low write lost");
	property p_wide_wr;
		I_WR && I_ADDR == 8'h05 ##1 !I_RD ##1 I_WR && I_ADDR == 8'h01
		|=> O_CMP[9:0] == {$past(I_WDATA[1:0], 3), $past(I_WDATA)};
	endproperty
	a_wide_wr: assert property (p_wide_wr)
		else $error("wide write wrong");
	property p_rd_hi;
		I_RD && I_ADDR == 8'h01 ##1 !I_WR ##1 I_RD && I_ADDR == 8'h05
		|=> O_RDATA == {6'h00, $past(O_CMP[9:8], 3)};
	endproperty
	a_rd_hi: assert property (p_rd_hi)
		else $error("high bits not captured");
	property p_keep;
		I_WR && I_ADDR == 8'h01 ##1 !I_RD ##1 I_WR && I_ADDR == 8'h02
		|=> O_CMP[19:18] == $past(O_CMP[9:8]);
	endproperty
	a_keep: assert property (p_keep)
		else $error("latch lost over write");
	property p_share;
		I_RD && I_ADDR == 8'h00 ##1 !I_WR ##1 I_WR && I_ADDR == 8'h03
		|=> O_CMP[29:28] == $past(O_COUNT[9:8], 3);
	endproperty
	a_share: assert property (p_share)
		else $error("latch not shared");
	property p_mask_off;
		I_WR && I_ADDR == 8'h0A && !I_WDATA[0] |=> !O_IRQ;
	endproperty
	a_mask_off: assert property (p_mask_off)
		else $error("masked irq still high");
	property p_unmapped;
		I_RD && I_ADDR > 8'h0A |=> O_RDATA == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
endmodule

bind pfg_top pfg_checker #(.NCMP(NCMP), .NPIN(NPIN)) u_chk (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
	.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
	.I_WAVE(I_WAVE), .I_PORT_OUT(I_PORT_OUT), .O_PIN(O_PIN), .O_COUNT(O_COUNT),
	.O_CMP(O_CMP), .O_IRQ(O_IRQ));

// *** tb/pfg_cpu_model.sv ***
// byte bus master standing in for the processor
module pfg_cpu_model
	import pfg_pkg::*;
(
	input  wire logic      i_clk,   // clock
	input  wire pfg_byte_t i_rdata, // read data
	output logic [7:0]     o_addr,  // address
	output logic [7:0]     o_wdata, // write data
	output logic           o_wr,    // write strobe
	output logic           o_rd     // read strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		#1; // let the written state settle before callers look
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask
	// latch first, then low byte; nothing may come between
	task automatic wr10(input logic [7:0] a, input logic [9:0] v);
		wr(8'h05, {6'h00, v[9:8]});
		wr(a, v[7:0]);
	endtask
	// low byte first, then latch
	task automatic rd10(input logic [7:0] a, output logic [9:0] v);
		logic [7:0] lo;
		logic [7:0] hi;
		rd(a, lo);
		rd(8'h05, hi);
		v = {hi[1:0], lo};
	endtask
endmodule

// *** tb/pfg_top_tb.sv ***
module pfg_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pfg_pkg::*;
	logic       clk, arst_n, tick, ext, cmp_in, wr, rd, irq;
	logic [7:0] addr, wdata;
	pfg_byte_t  rdata;
	logic [5:0] wave, pout, pin;
	pfg_wide_t  cnt;
	logic [39:0] cmpv;
	int         num_errors = 0;
	int         n_checks = 0;

	pfg_top DUT (.I_CLK(clk), .I_ARST_N(arst_n), .I_TICK(tick), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_EXT_PIN(ext),
		.I_CMP_RESULT(cmp_in), .I_WAVE(wave), .I_PORT_OUT(pout), .O_PIN(pin),
		.O_COUNT(cnt), .O_CMP(cmpv), .O_IRQ(irq));
	pfg_cpu_model m (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd));

	// clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		#1;
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic results();
		if (num_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// flip one trigger line, count edges until irq
	task automatic trip(input bit c, output int n);
		@(posedge clk);
		if (c) cmp_in <= ~cmp_in;
		else ext <= ~ext;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (irq !== 1'b1 && n < 20);
	endtask
	// both lines low, then arm with a fresh flag
	task automatic arm(input logic [7:0] cd);
		@(posedge clk);
		ext <= 1'b0;
		cmp_in <= 1'b0;
		repeat (8) @(posedge clk);
		m.wr(8'h08, cd);
		m.wr(8'h09, 8'h01);
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		results();
	end
	// main sequence
	initial begin
		logic [7:0] d;
		logic [9:0] v;
		int n;
		arst_n = 1'b0;
		tick = 1'b0;
		ext = 1'b0;
		cmp_in = 1'b0;
		wave = 6'h2A;
		pout = 6'h15;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// wide access through the shared latch
		m.wr10(8'h01, 10'h234);
		m.wr(8'h02, 8'h56);
		chk("cmp a", 16'h0234, 16'(cmpv[9:0]));
		chk("cmp b", 16'h0256, 16'(cmpv[19:10]));
		m.wr(8'h04, 8'h78);
		chk("cmp d", 16'h0278, 16'(cmpv[39:30]));
		m.rd10(8'h02, v);
		chk("rd b", 16'h0256, 16'(v));
		m.rd10(8'h01, v);
		chk("rd a", 16'h0234, 16'(v));
		m.wr10(8'h00, 10'h1FF);
		m.rd(8'h00, d);
		m.wr(8'h03, 8'h11);
		chk("cmp c", 16'h0111, 16'(cmpv[29:20]));
		@(posedge clk);
		tick <= 1'b1;
		repeat (10) @(posedge clk);
		tick <= 1'b0;
		#1;
		chk("count", 16'h0209, 16'(cnt));
		m.rd(8'h20, d);
		chk("unmapped", 16'h0000, 16'(d));
		// fault per source, filter off and on
		m.wr(8'h0A, 8'h01);
		for (int s = 0; s < 4; s++) begin
			m.wr(8'h06, 8'h50);
			m.wr(8'h07, 8'h01);
			chk("pins on", 16'(wave), 16'(pin));
			arm({3'h0, 1'b1, 1'b1, s[1], s[0], 1'b1});
			chk("irq idle", 16'h0000, 16'(irq));
			trip(~s[0], n);
			chk("other src", 16'd20, 16'(n));
			trip(s[0], n);
			chk("delay", 16'(2 + 4 * s[1]), 16'(n));
			chk("pins off", 16'(pout), 16'(pin));
			m.rd(8'h08, d);
			chk("ctrl d", 16'({2'h0, 1'b1, 1'b1, 1'b1, s[1], s[0], 1'b0}), 16'(d));
			m.rd(8'h06, d);
			chk("modes", 16'h0000, 16'(d));
			m.wr(8'h09, 8'h01);
			chk("irq clr", 16'h0000, 16'(irq));
		end
		// short pulse must not pass the filter
		arm(8'h1D);
		@(posedge clk);
		ext <= 1'b1;
		repeat (3) @(posedge clk);
		ext <= 1'b0;
		repeat (10) @(posedge clk);
		chk("glitch", 16'h0000, 16'(irq));
		// source switch with unequal levels trips
		arm(8'h19);
		@(posedge clk);
		cmp_in <= 1'b1;
		repeat (4) @(posedge clk);
		m.wr(8'h08, 8'h1B);
		repeat (4) @(posedge clk);
		chk("switch", 16'h0001, 16'(irq));
		m.wr(8'h0A, 8'h00);
		chk("masked", 16'h0000, 16'(irq));
		m.rd(8'h09, d);
		chk("sticky", 16'h0001, 16'(d));
		results();
	end
endmodule
